// *** timer_consts.svh ***
// Register offsets, field positions, reset values and counts of the timer control block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Byte addresses on the register bus
`define TIMER_CONTROL_OFFSET   8'h00
`define COUNT_REGISTER_OFFSET  8'h04

// Field positions in timer_control
`define ENABLE_BIT             15
`define STOP_IN_IDLE_BIT       13
`define ASYNC_WRITE_BLOCK_BIT  12
`define ASYNC_WRITE_PENDING_BIT 11
`define GATE_ENABLE_BIT        7
`define PRESCALE_HI_BIT        5
`define PRESCALE_LO_BIT        4
`define EXT_SYNC_BIT           2
`define SOURCE_BIT             1

// Bits that software may write; all others except the pending flag, bit 11, read as zero
`define CONTROL_WRITE_MASK     16'hb0b6

// Reset values
`define CONTROL_RESET          16'h0000
`define COUNT_RESET            16'h0000

// Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256
`define PRESCALE_LIMIT_1       8'h00
`define PRESCALE_LIMIT_8       8'h07
`define PRESCALE_LIMIT_64      8'h3f
`define PRESCALE_LIMIT_256     8'hff

`endif

// *** timer_pkg.sv ***
// Types shared by the timer control block
package timer_pkg;

    // Progress of a counter write in asynchronous counting mode
    typedef enum logic [0:0] {
        WRITE_IDLE    = 1'b0,
        WRITE_PENDING = 1'b1
    } async_write_state_type;

    // Prescale field encodings
    typedef enum logic [1:0] {
        PRESCALE_DIV_1   = 2'b00,
        PRESCALE_DIV_8   = 2'b01,
        PRESCALE_DIV_64  = 2'b10,
        PRESCALE_DIV_256 = 2'b11
    } prescale_type;

endpackage

// *** sync_flop2.sv ***
// Two-stage synchroniser for inputs from outside the clock domain
module sync_flop2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    // Asynchronous input and synchronised copy
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_one_q;
    logic [WIDTH-1:0] stage_two_q;

    // First stage is read only by the second
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_one_q <= '0;
            stage_two_q <= '0;
        end else begin
            stage_one_q <= async_i;
            stage_two_q <= stage_one_q;
        end
    end

    assign sync_o = stage_two_q;

endmodule // sync_flop2

// *** type_a_timer_control.sv ***
// Timer control register, prescaler, counter and write-protection logic
// Behaviour
// - Timer counts only while enable bit set
// - Stop-in-idle set halts counting during idle
// - Write block ignores counter writes while pending
// - Write block clear accepts back-to-back counter writes
// - Pending flag reads one during asynchronous write
// - Pending flag reads zero in synchronous mode
// - Gate enable works only with internal clock
// - Prescale field divides by 1, 8, 64, 256
// - Sync bit chooses external synchronisation; else ignored (pin always synchronised; bit clear holds counter writes to next edge)
// - Source bit selects external pin or internal
// - Unimplemented control bits read zero, ignore writes
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`include "timer_consts.svh"

module type_a_timer_control (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Device power state
    input  wire logic        idle_mode_i,
    // Pins
    input  wire logic        external_count_pin_i,
    input  wire logic        gate_pin_i,
    // Status
    output logic      [15:0] count_value_o
);

    // Synchronised pins
    logic [1:0]  pins_sync;
    logic        ext_pin_sync;
    logic        gate_sync;

    // Bus state
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [15:0] control_q;
    logic [15:0] control_d;

    // Counting state
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic [7:0]  prescale_q;
    logic [7:0]  prescale_d;
    logic        ext_prev_q;
    logic        ext_prev_d;
    timer_pkg::async_write_state_type write_state_q;
    timer_pkg::async_write_state_type write_state_d;

    // Decoded controls
    logic        access;
    logic        control_wr;
    logic        count_wr;
    logic [15:0] lane_mask;
    logic [15:0] count_merged;
    logic [15:0] control_read;
    logic        async_mode;
    logic        running;
    logic        ext_edge;
    logic        gated_mode;
    logic        source_tick;
    logic [7:0]  prescale_limit;
    logic        pending_flag;
    logic        prescale_wrap;
    logic        write_land;
    logic        write_take;

    // Pins cross into the clock domain before any use
    sync_flop2 #(
        .WIDTH (2)
    ) pin_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   ({gate_pin_i, external_count_pin_i}),
        .sync_o    (pins_sync)
    );

    assign ext_pin_sync = pins_sync[0];
    assign gate_sync    = pins_sync[1];

    // Bus decode; one access per request, answered next edge
    assign access     = wb_cyc_i && wb_stb_i && !ack_q;
    assign control_wr = access && wb_we_i && (wb_adr_i == `TIMER_CONTROL_OFFSET);
    assign count_wr   = access && wb_we_i && (wb_adr_i == `COUNT_REGISTER_OFFSET);
    assign lane_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Byte lanes merge onto the live count
    assign count_merged = (count_q & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);

    // Asynchronous mode: external source without synchronisation
    assign async_mode = control_q[`SOURCE_BIT] && !control_q[`EXT_SYNC_BIT];

    // Pending flag hidden outside asynchronous mode
    assign pending_flag = (write_state_q == timer_pkg::WRITE_PENDING)
                          && async_mode;

    // Read view; stored bits are writable ones only
    always_comb begin
        control_read = control_q;
        control_read[`ASYNC_WRITE_PENDING_BIT] = pending_flag;
    end

    // Next state of bus answer; read data hold until the next read
    always_comb begin
        ack_d   = access;
        rdata_d = rdata_q;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                `TIMER_CONTROL_OFFSET:  rdata_d = {16'h0000, control_read};
                `COUNT_REGISTER_OFFSET: rdata_d = {16'h0000, count_q};
                default:                rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Next control value; the write mask keeps reserved bits at zero
    always_comb begin
        control_d = control_q;
        if (control_wr) begin
            control_d = (control_q & ~lane_mask)
                        | (wb_dat_i[15:0] & lane_mask & `CONTROL_WRITE_MASK);
        end
    end

    // Control register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control_q <= `CONTROL_RESET;
        end else begin
            control_q <= control_d;
        end
    end

    // Enable and idle decide whether the timer runs
    assign running = control_q[`ENABLE_BIT]
                     && !(control_q[`STOP_IN_IDLE_BIT] && idle_mode_i);

    // Rising edge of the synchronised external clock
    assign ext_edge = ext_pin_sync && !ext_prev_q;

    // Edge detector follows the synchronised pin
    always_comb begin
        ext_prev_d = ext_pin_sync;
    end

    // Edge detector resets to the idle low level, so no false edge follows reset
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_prev_d;
        end
    end

    // Gate only matters with the internal clock
    assign gated_mode = !control_q[`SOURCE_BIT] && control_q[`GATE_ENABLE_BIT];

    // Count source before the prescaler
    always_comb begin
        if (control_q[`SOURCE_BIT]) begin
            source_tick = ext_edge;
        end else if (gated_mode) begin
            source_tick = gate_sync;
        end else begin
            source_tick = 1'b1;
        end
    end

    // Terminal count of the prescaler
    always_comb begin
        case (timer_pkg::prescale_type'(control_q[`PRESCALE_HI_BIT:`PRESCALE_LO_BIT]))
            timer_pkg::PRESCALE_DIV_1:   prescale_limit = `PRESCALE_LIMIT_1;
            timer_pkg::PRESCALE_DIV_8:   prescale_limit = `PRESCALE_LIMIT_8;
            timer_pkg::PRESCALE_DIV_64:  prescale_limit = `PRESCALE_LIMIT_64;
            timer_pkg::PRESCALE_DIV_256: prescale_limit = `PRESCALE_LIMIT_256;
            default:                     prescale_limit = `PRESCALE_LIMIT_1;
        endcase
    end

    // Next prescaler value; a stopped timer clears it so a restart is clean
    always_comb begin
        prescale_d    = prescale_q;
        prescale_wrap = 1'b0;
        if (!running) begin
            prescale_d = 8'h00;
        end else if (source_tick) begin
            if (prescale_q >= prescale_limit) begin
                prescale_d    = 8'h00;
                prescale_wrap = 1'b1;
            end else begin
                prescale_d = prescale_q + 8'h01;
            end
        end
    end

    // Prescaler register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prescale_q <= 8'h00;
        end else begin
            prescale_q <= prescale_d;
        end
    end

    // Held write lands on the next external edge; leaving asynchronous
    // mode flushes it at once, since no edge may follow there
    assign write_land = (write_state_q == timer_pkg::WRITE_PENDING)
                        && (ext_edge || !async_mode);

    // Asynchronous counter write taken unless a pending one blocks it
    assign write_take = count_wr && async_mode
                        && !(control_q[`ASYNC_WRITE_BLOCK_BIT]
                             && write_state_q == timer_pkg::WRITE_PENDING);

    // Next state of the write path; a new write beats a landing one
    always_comb begin
        hold_d        = hold_q;
        write_state_d = write_state_q;
        case (write_state_q)
            timer_pkg::WRITE_IDLE: begin
                write_state_d = timer_pkg::WRITE_IDLE;
            end
            timer_pkg::WRITE_PENDING: begin
                if (write_land) begin
                    write_state_d = timer_pkg::WRITE_IDLE;
                end
            end
            default: begin
                write_state_d = timer_pkg::WRITE_IDLE;
            end
        endcase
        if (write_take) begin
            hold_d        = count_merged;
            write_state_d = timer_pkg::WRITE_PENDING;
        end
    end

    // Write path registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_q        <= `COUNT_RESET;
            write_state_q <= timer_pkg::WRITE_IDLE;
        end else begin
            hold_q        <= hold_d;
            write_state_q <= write_state_d;
        end
    end

    // Next count; a landing write beats a tick, a direct write beats both
    always_comb begin
        count_d = count_q;
        if (prescale_wrap) begin
            count_d = count_q + 16'h0001;
        end
        if (write_land) begin
            count_d = hold_q;
        end
        if (count_wr && !async_mode) begin
            count_d = count_merged;
        end
    end

    // Counter register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= `COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = rdata_q;
    assign count_value_o = count_q;

endmodule // type_a_timer_control

// *** ext_pin_model.sv ***
// Far-side model of the external count pin
module ext_pin_model (
    // Clock
    input  wire logic       clock_i,
    // Bench control: run and half period in cycles minus one
    input  wire logic       run_i,
    input  wire logic [3:0] half_i,
    // Pin
    output logic            pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0;
    logic       pin_q = 1'b0;
    assign pin_o = pin_q;
    // Clock stands still low when stopped; a begun high phase always finishes
    always @(posedge clock_i) begin
        if (!run_i && !pin_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= half_i) begin
            cnt_q <= 4'h0;
            pin_q <= !pin_q;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // ext_pin_model

// *** type_a_timer_control_checker.sv ***
// Port-level assertions for the timer control block
`include "timer_consts.svh"
module timer_ctl_checker (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        idle_mode_i,
    input wire logic        gate_pin_i,
    input wire logic [15:0] count_value_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic        req, wr, rd0, steady, run1;
    logic [15:0] ctl_q, ctl_d, old_q, lanes;
    // Byte lane 0 holds bits 7:0, lane 1 bits 15:8
    assign lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd0 = req && !wb_we_i && wb_adr_i == `TIMER_CONTROL_OFFSET;
    // Internal source, no write, control unchanged for a cycle: no pending write can land
    assign steady = old_q == ctl_q && !wr && !ctl_q[1];
    assign run1 = ctl_q[15] && !(ctl_q[13] && idle_mode_i);
    // Shadow of the writable control bits
    always_comb begin
        ctl_d = ctl_q;
        if (wr && wb_adr_i == `TIMER_CONTROL_OFFSET) begin
            ctl_d = (ctl_q & ~lanes) | (wb_dat_i[15:0] & lanes & `CONTROL_WRITE_MASK);
        end
    end
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_q <= `CONTROL_RESET;
            old_q <= `CONTROL_RESET;
        end else begin
            ctl_q <= ctl_d;
            old_q <= ctl_q;
        end
    end
    property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
    property p_off; steady && !ctl_q[15] |=> $stable(count_value_o); endproperty
    a_off: assert property (p_off) else $error("count moved while off");
    property p_idle; steady && ctl_q[15] && ctl_q[13] && idle_mode_i |=> $stable(count_value_o);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved in idle");
    property p_every; steady && run1 && ctl_q[7:4] == 4'h0
        |=> count_value_o == $past(count_value_o) + 16'h0001; endproperty
    a_every: assert property (p_every) else $error("no step at 1:1");
    property p_gate; (!gate_pin_i)[*4] ##0 (steady && ctl_q[7]) |=> $stable(count_value_o);
    endproperty
    a_gate: assert property (p_gate) else $error("count moved with gate low");
    property p_rdc; rd0 |=> (wb_dat_o & 32'hffff4749) == 32'h0
        && (wb_dat_o[15:0] & `CONTROL_WRITE_MASK) == $past(ctl_q); endproperty
    a_rdc: assert property (p_rdc) else $error("control readback wrong");
    property p_flag; rd0 && old_q == ctl_q && !(ctl_q[1] && !ctl_q[2]) |=> !wb_dat_o[11];
    endproperty
    a_flag: assert property (p_flag) else $error("pending flag set in sync mode");
    property p_cnt; req && !wb_we_i && wb_adr_i == `COUNT_REGISTER_OFFSET
        |=> wb_dat_o == {16'h0000, $past(count_value_o)}; endproperty
    a_cnt: assert property (p_cnt) else $error("count readback wrong");
    property p_unm; req && !wb_we_i && wb_adr_i != 8'h00 && wb_adr_i != 8'h04
        |=> wb_dat_o == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // timer_ctl_checker

bind type_a_timer_control timer_ctl_checker u_chk (.clock_i, .reset_n_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .idle_mode_i,
    .gate_pin_i, .count_value_o);

// *** test_type_a_timer_control.sv ***
// Self-checking bench for the timer control block
module test_type_a_timer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, idle_mode_i = 1'b0, gate_pin_i = 1'b0, run = 1'b0;
    logic        external_count_pin_i, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf, half = 4'h4;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [15:0] count_value_o, c0;
    int          fail_count = 0, checks_done = 0, cycles = 0, g, n;
    int          dv [4] = '{1, 8, 64, 256};
    always #50 clock_i = !clock_i;
    type_a_timer_control u_dut (.clock_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .idle_mode_i,
        .external_count_pin_i, .gate_pin_i, .count_value_o);
    ext_pin_model u_pin (.clock_i, .run_i(run), .half_i(half), .pin_o(external_count_pin_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the idle cycle after it keeps software off the bus after a stop
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clock_i);
        while (wb_ack_o !== 1'b1) @(posedge clock_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Released bus shows the inverse, so only a qualified request can count
        wb_we_i <= !we;
        wb_adr_i <= ~a;
        wb_dat_i <= ~d;
        @(posedge clock_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Cycles between two count steps, left in g
    task automatic gap();
        c0 = count_value_o;
        n = 0;
        while (count_value_o === c0 && n < 600) begin
            @(posedge clock_i);
            n++;
        end
        c0 = count_value_o;
        g = 0;
        while (count_value_o === c0 && g < 600) begin
            @(posedge clock_i);
            g++;
        end
        check(count_value_o, c0 + 16'h1);
    endtask
    task automatic hold();
        c0 = count_value_o;
        repeat (20) @(posedge clock_i);
        check(count_value_o, c0);
    endtask
    // Exactly one rising edge on the pin
    task automatic pulse();
        run <= 1'b1;
        while (external_count_pin_i !== 1'b1) @(posedge clock_i);
        run <= 1'b0;
        repeat (16) @(posedge clock_i);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, well above the thousand or so cycles the sequence needs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'hffffffff);
        rc(8'h00, 32'h0000b0b6);
        rc(8'h08, 32'h0);
        hold();
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, 8'h00, 32'h8000 | (p << 4));
            gap();
            check(g, dv[p]);
        end
        bus(1'b1, 8'h00, 32'h0);
        hold();
        // Idle first, so the enable never sees a running cycle
        idle_mode_i <= 1'b1;
        bus(1'b1, 8'h00, 32'ha000);
        hold();
        bus(1'b1, 8'h00, 32'h8000);
        gap();
        check(g, 1);
        idle_mode_i <= 1'b0;
        bus(1'b1, 8'h00, 32'h8080);
        hold();
        gate_pin_i <= 1'b1;
        gap();
        check(g, 1);
        gate_pin_i <= 1'b0;
        bus(1'b1, 8'h00, 32'h8086);
        run <= 1'b1;
        gap();
        check(g, 10);
        bus(1'b1, 8'h00, 32'h8082);
        gap();
        check(g, 10);
        bus(1'b1, 8'h00, 32'h8086);
        run <= 1'b0;
        repeat (16) @(posedge clock_i);
        bus(1'b1, 8'h04, 32'h0055);
        rc(8'h04, 32'h0055);
        rc(8'h00, 32'h8086);
        wb_sel_i <= 4'h2;
        bus(1'b1, 8'h04, 32'hab99);
        wb_sel_i <= 4'hf;
        rc(8'h04, 32'hab55);
        bus(1'b1, 8'h00, 32'h9002);
        bus(1'b1, 8'h04, 32'h1234);
        rc(8'h00, 32'h9802);
        bus(1'b1, 8'h04, 32'h5678);
        rc(8'h04, 32'hab55);
        pulse();
        rc(8'h00, 32'h9002);
        rc(8'h04, 32'h1234);
        bus(1'b1, 8'h00, 32'h8002);
        bus(1'b1, 8'h04, 32'h1111);
        bus(1'b1, 8'h04, 32'h2222);
        rc(8'h00, 32'h8802);
        pulse();
        rc(8'h04, 32'h2222);
        complete_run();
    end
endmodule // test_type_a_timer_control
